// [src/serial_ctrl3_top.sv]
// Serial transceiver control with mode bits, flow control and AXI4-Lite registers
// Assumes flow-control and line pins synchronous to core_clk_i
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "serial_ctrl3_consts.svh"

module serial_ctrl3_top
  import serial_ctrl3_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // AXI4-Lite write response
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  // AXI4-Lite read data
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // Serial lines
  input  wire logic        rx_i,
  output logic             tx_o,
  output logic             tx_oe_o,
  input  wire logic        cts_b_i,
  output logic             rts_b_o,
  output logic             ir_low_power_o,
  // DMA and interrupt
  output logic             dma_rx_req_o,
  output logic             dma_tx_req_o,
  output logic             irq_o
);
  import serial_ctrl3_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic       rst_meta;
  logic       rst_b;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_b    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b    <= rst_meta;
    end
  end

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  serial_cfg_if cfg ();

  ctrl3_type   serial_control_three;
  logic        enable;
  logic [15:0] baud_div;
  logic [4:0]  status;
  logic [4:0]  irq_mask;
  logic [7:0]  tx_hold;
  logic        tx_full;
  logic [7:0]  rx_hold;
  logic        rx_full;
  logic        cts_prev;
  logic        tx_start;
  logic        tx_busy;
  logic        tx_line;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        line_in;

  // Bus handshakes
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_ok;
  logic        rd_take;
  logic        rx_read;
  logic [4:0]  set_bits;
  logic [4:0]  clr_bits;

  // ****************************************************************
  // AXI4-Lite write side
  // ****************************************************************
  assign awready_o = !aw_got && !bvalid_o;
  assign wready_o  = !w_got && !bvalid_o;
  assign do_write  = aw_got && w_got && !bvalid_o;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o  <= 2'b00;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_got  <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (do_write) begin
        aw_got   <= 1'b0;
        w_got    <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o  <= wr_ok ? 2'b00 : 2'b10;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr)
      `OFS_CONTROL_ONE, `OFS_CONTROL_THREE, `OFS_STATUS,
      `OFS_IRQ_MASK, `OFS_TX_DATA, `OFS_BAUD: wr_ok = 1'b1;
      default:                               wr_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      serial_control_three <= `CTRL3_RESET;
      enable               <= 1'b0;
      baud_div             <= `BAUD_RESET;
      irq_mask             <= 5'h00;
    end else if (do_write) begin
      if (aw_addr == `OFS_CONTROL_ONE && w_strb[0]) begin
        enable <= w_data[`BIT_ENABLE];
      end
      if (aw_addr == `OFS_CONTROL_THREE) begin
        // Mode bits are frozen while running; DMA and irq enables stay free
        if (!enable && w_strb[0]) begin
          serial_control_three[7:0] <= w_data[7:0];
        end else if (w_strb[0]) begin
          serial_control_three[7:6] <= w_data[7:6];
        end
        if (!enable && w_strb[1]) begin
          serial_control_three[11:8] <= w_data[11:8];
        end else if (w_strb[1]) begin
          serial_control_three[`BIT_CTS_IRQ] <= w_data[`BIT_CTS_IRQ];
        end
      end
      if (aw_addr == `OFS_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[4:0];
      end
      if (aw_addr == `OFS_BAUD) begin
        if (w_strb[0]) baud_div[7:0]  <= w_data[7:0];
        if (w_strb[1]) baud_div[15:8] <= w_data[15:8];
      end
    end
  end

  assign cfg.ir_low_power      = serial_control_three[`BIT_IR_LOW_POWER];
  assign cfg.half_duplex_on    = serial_control_three[`BIT_HALF_DUPLEX];
  assign cfg.smartcard_nack_on = serial_control_three[`BIT_SC_NACK];
  assign cfg.smartcard_on      = serial_control_three[`BIT_SMARTCARD];
  assign cfg.single_sample_sel = serial_control_three[`BIT_SINGLE_SAMPLE];
  assign cfg.baud_div          = baud_div;
  assign cfg.enable            = enable;

  assign ir_low_power_o = enable & serial_control_three[`BIT_IR_LOW_POWER];

  // ****************************************************************
  // Transmit path with clear-to-send gating
  // ****************************************************************
  // Character waits in the holding slot until the partner permits
  assign tx_start = enable && tx_full && !tx_busy &&
                    (!serial_control_three[`BIT_CTS] || !cts_b_i);

  // Busy shifter ignores the gate, so a started character always completes
  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
    end else begin
      if (tx_start) begin
        tx_full <= 1'b0;
      end
      if (do_write && aw_addr == `OFS_TX_DATA && w_strb[0] && !tx_full) begin
        tx_hold <= w_data[7:0];
        tx_full <= 1'b1;
      end
    end
  end

  serial_tx_shift u_tx (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b),
    .start_i (tx_start),
    .data_i  (tx_hold),
    .cfg     (cfg.tx),
    .line_o  (tx_line),
    .busy_o  (tx_busy)
  );

  // Half duplex: drive the shared pin only while sending
  assign tx_o    = tx_line;
  assign tx_oe_o = serial_control_three[`BIT_HALF_DUPLEX] ? tx_busy : 1'b1;
  assign line_in = serial_control_three[`BIT_HALF_DUPLEX] ?
                   (tx_busy ? 1'b1 : tx_line & rx_i) : rx_i;

  // ****************************************************************
  // Receive path and request-to-send
  // ****************************************************************
  serial_rx_shift u_rx (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b),
    .line_i  (line_in),
    .cfg     (cfg.rx),
    .data_o  (rx_data),
    .done_o  (rx_done)
  );

  assign rx_read = rd_take && araddr_i == `OFS_RX_DATA;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_done) begin
      rx_hold <= rx_data;
      rx_full <= 1'b1;
    end else if (rx_read) begin
      rx_full <= 1'b0;
    end
  end

  // Low while the block is enabled and a free slot exists; high when disabled by the bit
  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rts_b_o <= 1'b1;
    end else begin
      rts_b_o <= !(serial_control_three[`BIT_RTS] && enable && !rx_full);
    end
  end

  assign dma_rx_req_o = serial_control_three[`BIT_DMA_RX] && rx_full;
  assign dma_tx_req_o = serial_control_three[`BIT_DMA_TX] && !tx_full;

  // ****************************************************************
  // Status and interrupt
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cts_prev <= 1'b1;
    end else begin
      cts_prev <= cts_b_i;
    end
  end

  always_comb begin
    set_bits = 5'h00;
    set_bits[`ST_CTS_CHANGE] = serial_control_three[`BIT_CTS] && (cts_prev != cts_b_i);
    set_bits[`ST_NOISE]      = cfg.noise_seen;
    set_bits[`ST_PARITY]     = cfg.parity_error;
    clr_bits = 5'h00;
    if (do_write && aw_addr == `OFS_STATUS && w_strb[0]) begin
      clr_bits = w_data[4:0] & `STICKY_MASK;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      status <= `STATUS_RESET;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
      status[`ST_RX_FULL]  <= rx_full;
      status[`ST_TX_EMPTY] <= !tx_full;
    end
  end

  // CTS change reaches the pin through its own enable or the mask
  assign irq_o = |(status & irq_mask & `STICKY_MASK) ||
                 (status[`ST_CTS_CHANGE] && serial_control_three[`BIT_CTS_IRQ]);

  // ****************************************************************
  // AXI4-Lite read side
  // ****************************************************************
  assign arready_o = !rvalid_o;
  assign rd_take   = arvalid_i && arready_o;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0000_0000;
      rresp_o  <= 2'b00;
    end else if (rd_take) begin
      rvalid_o <= 1'b1;
      rresp_o  <= 2'b00;
      case (araddr_i)
        `OFS_CONTROL_ONE:   rdata_o <= {31'h0000_0000, enable};
        `OFS_CONTROL_THREE: rdata_o <= {20'h0_0000, serial_control_three};
        `OFS_STATUS:        rdata_o <= {26'h000_0000, !cts_b_i, status};
        `OFS_IRQ_MASK:      rdata_o <= {27'h000_0000, irq_mask};
        `OFS_TX_DATA:       rdata_o <= {24'h00_0000, tx_hold};
        `OFS_RX_DATA:       rdata_o <= {24'h00_0000, rx_hold};
        `OFS_BAUD:          rdata_o <= {16'h0000, baud_div};
        default: begin
          rdata_o <= 32'h0000_0000;
          rresp_o <= 2'b10;
        end
      endcase
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end
  end
endmodule

// [src/serial_ctrl3_consts.svh]
// Offsets, field positions, reset values and timing counts of the serial control block
// Assumes inclusion by bare name from every file that needs them
`ifndef SERIAL_CTRL3_CONSTS_SVH
`define SERIAL_CTRL3_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_CONTROL_ONE      8'h00
`define OFS_CONTROL_THREE    8'h08
`define OFS_STATUS           8'h0c
`define OFS_IRQ_MASK         8'h10
`define OFS_TX_DATA          8'h14
`define OFS_RX_DATA          8'h18
`define OFS_BAUD             8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_ENABLE           0
`define BIT_IR_LOW_POWER     2
`define BIT_HALF_DUPLEX      3
`define BIT_SC_NACK          4
`define BIT_SMARTCARD        5
`define BIT_DMA_RX           6
`define BIT_DMA_TX           7
`define BIT_RTS              8
`define BIT_CTS              9
`define BIT_CTS_IRQ          10
`define BIT_SINGLE_SAMPLE    11
`define CTRL3_LOCKED_MASK    12'hb3c
`define CTRL3_FREE_MASK      12'h4c0

`define ST_CTS_CHANGE        0
`define ST_RX_FULL           1
`define ST_TX_EMPTY          2
`define ST_NOISE             3
`define ST_PARITY            4
`define ST_CTS_LEVEL         5

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CTRL3_RESET          12'h000
`define BAUD_RESET           16'h0010
`define STATUS_RESET         5'h04
`define STICKY_MASK          5'h19

`endif

// [src/serial_ctrl3_pkg.sv]
// Types shared by the serial control block
// Assumes nothing beyond a SystemVerilog compiler
package serial_ctrl3_pkg;

  typedef enum logic [1:0] {
    LINE_IDLE   = 2'b00,
    LINE_START  = 2'b01,
    LINE_DATA   = 2'b11,
    LINE_STOP   = 2'b10
  } line_state_type;

  typedef logic [11:0] ctrl3_type;

endpackage

// [src/serial_cfg_if.sv]
// Configuration and status carried between the control top and its shifters
// Assumes one clock domain
`timescale 1ns/10ps
interface serial_cfg_if;
  logic        ir_low_power;
  logic        half_duplex_on;
  logic        smartcard_on;
  logic        smartcard_nack_on;
  logic        single_sample_sel;
  logic [15:0] baud_div;
  logic        enable;
  logic        parity_error;
  logic        noise_seen;
  logic        nack_request;

  modport top (output ir_low_power, half_duplex_on, smartcard_on, smartcard_nack_on,
               output single_sample_sel, baud_div, enable,
               input  parity_error, noise_seen, nack_request);
  modport rx  (input  ir_low_power, half_duplex_on, smartcard_on, smartcard_nack_on,
               input  single_sample_sel, baud_div, enable,
               output parity_error, noise_seen, nack_request);
  modport tx  (input  ir_low_power, half_duplex_on, smartcard_on, smartcard_nack_on,
               input  single_sample_sel, baud_div, enable,
               input  parity_error, noise_seen, nack_request);
endinterface

// [src/serial_rx_shift.sv]
// Receive shifter: start detect, bit sampling, even parity check
// Assumes rx line already synchronous to the clock
`timescale 1ns/10ps
`include "serial_ctrl3_consts.svh"
module serial_rx_shift
  import serial_ctrl3_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Line and config
  input  wire logic       line_i,
  serial_cfg_if.rx        cfg,
  // Received character
  output logic [7:0]      data_o,
  output logic            done_o
);
  import serial_ctrl3_pkg::*;

  line_state_type state;
  logic [15:0]    tick;
  logic [3:0]     bitn;
  logic [2:0]     hist;
  logic [8:0]     shreg;
  logic           vote;
  logic           sample;
  logic [15:0]    half;

  assign half   = {1'b0, cfg.baud_div[15:1]};
  // Majority of three taken around mid bit
  assign vote   = (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);
  assign sample = cfg.single_sample_sel ? hist[1] : vote;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hist <= 3'h7;
    end else begin
      hist <= {hist[1:0], line_i};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state            <= LINE_IDLE;
      tick             <= 16'h0000;
      bitn             <= 4'h0;
      shreg            <= 9'h000;
      data_o           <= 8'h00;
      done_o           <= 1'b0;
      cfg.parity_error <= 1'b0;
      cfg.noise_seen   <= 1'b0;
      cfg.nack_request <= 1'b0;
    end else begin
      done_o           <= 1'b0;
      cfg.noise_seen   <= 1'b0;
      cfg.parity_error <= 1'b0;
      cfg.nack_request <= 1'b0;
      case (state)
        LINE_IDLE: begin
          tick <= 16'h0000;
          if (cfg.enable && !line_i) begin
            state <= LINE_START;
          end
        end
        LINE_START: begin
          tick <= tick + 16'h0001;
          if (tick >= half) begin
            tick  <= 16'h0000;
            bitn  <= 4'h0;
            state <= line_i ? LINE_IDLE : LINE_DATA;
          end
        end
        LINE_DATA: begin
          tick <= tick + 16'h0001;
          if (tick >= cfg.baud_div) begin
            tick  <= 16'h0000;
            shreg <= {sample, shreg[8:1]};
            bitn  <= bitn + 4'h1;
            // Disagreeing samples count as noise only in three-sample mode
            if (!cfg.single_sample_sel && (hist != 3'h0) && (hist != 3'h7)) begin
              cfg.noise_seen <= 1'b1;
            end
            if (bitn == 4'h8) begin
              state <= LINE_STOP;
            end
          end
        end
        LINE_STOP: begin
          tick <= tick + 16'h0001;
          if (tick >= cfg.baud_div) begin
            state  <= LINE_IDLE;
            data_o <= shreg[7:0];
            done_o <= 1'b1;
            if (^shreg) begin
              cfg.parity_error <= 1'b1;
              cfg.nack_request <= cfg.smartcard_on & cfg.smartcard_nack_on;
            end
          end
        end
        default: state <= LINE_IDLE;
      endcase
    end
  end
endmodule

// [src/serial_tx_shift.sv]
// Transmit shifter: start, eight data, even parity, stop; NACK slot on request
// Assumes the caller starts a character only when the gate allows it
`timescale 1ns/10ps
`include "serial_ctrl3_consts.svh"
module serial_tx_shift
  import serial_ctrl3_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Character request
  input  wire logic       start_i,
  input  wire logic [7:0] data_i,
  serial_cfg_if.tx        cfg,
  // Line
  output logic            line_o,
  output logic            busy_o
);
  import serial_ctrl3_pkg::*;

  logic [15:0] tick;
  logic [3:0]  left;
  logic [10:0] frame;
  logic [15:0] nack_cnt;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick   <= 16'h0000;
      left   <= 4'h0;
      frame  <= 11'h7ff;
      line_o <= 1'b1;
    end else begin
      if (left == 4'h0) begin
        line_o <= (nack_cnt != 16'h0000) ? 1'b0 : 1'b1;
        if (start_i) begin
          frame <= {1'b1, ^data_i, data_i, 1'b0};
          left  <= 4'hb;
          tick  <= 16'h0000;
        end
      end else begin
        line_o <= frame[0];
        tick   <= tick + 16'h0001;
        if (tick >= cfg.baud_div) begin
          tick  <= 16'h0000;
          frame <= {1'b1, frame[10:1]};
          left  <= left - 4'h1;
        end
      end
    end
  end

  // NACK pulls the line low for baud_div clocks, one less than a bit time, after a bad character
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nack_cnt <= 16'h0000;
    end else if (cfg.nack_request) begin
      nack_cnt <= cfg.baud_div;
    end else if (nack_cnt != 16'h0000) begin
      nack_cnt <= nack_cnt - 16'h0001;
    end
  end

  assign busy_o = (left != 4'h0) || (nack_cnt != 16'h0000);
endmodule

// [sim/serial_ctrl3_checker.sv]
// Port-level assertions for the serial control top
// Assumes registers change only through AXI4-Lite writes
`timescale 1ns/10ps
`include "serial_ctrl3_consts.svh"
module serial_ctrl3_checker (
  // Clock, reset, writes
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  awaddr_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic [1:0]  bresp_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  // Lines and requests
  input wire logic        tx_o,
  input wire logic        tx_oe_o,
  input wire logic        cts_b_i,
  input wire logic        rts_b_o,
  input wire logic        ir_low_power_o,
  input wire logic        dma_rx_req_o,
  input wire logic        dma_tx_req_o,
  input wire logic        irq_o
);
  // ****************
  // Register shadow
  // ****************
  logic [7:0]  adr;
  logic [11:0] dat;
  logic [11:0] c3;
  logic        en;
  logic        busy;
  logic        ok;
  logic [7:0]  hi;
  assign ok = bvalid_o && bready_i && bresp_o == 2'b00;
  // Busy hides the design's earlier update
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      adr  <= 8'h00;
      dat  <= 12'h000;
      busy <= 1'b0;
      en   <= 1'b0;
      c3   <= `CTRL3_RESET;
    end else begin
      if (awvalid_i && awready_o) adr <= awaddr_i;
      if (wvalid_i && wready_o) dat <= wdata_i[11:0];
      if (awvalid_i && awready_o) busy <= 1'b1;
      else if (bvalid_o && bready_i) busy <= 1'b0;
      if (ok && adr == `OFS_CONTROL_ONE) en <= dat[0];
      if (ok && adr == `OFS_CONTROL_THREE)
        c3 <= en ? (c3 & `CTRL3_LOCKED_MASK) | (dat & `CTRL3_FREE_MASK) : dat;
    end
  end
  // No frame stays high 200 clocks at reset baud, so above that the line is idle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) hi <= 8'h00;
    else if (!tx_o) hi <= 8'h00;
    else if (hi != 8'hff) hi <= hi + 8'h01;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  ir_power_a: assert property (!busy |-> ir_low_power_o == (en && c3[2]))
    else $error("low power output wrong");
  mode_lock_a: assert property (en && $past(en) && (!busy || adr != `OFS_CONTROL_ONE)
    |-> $stable(ir_low_power_o)) else $error("locked mode bit changed");
  rts_idle_a: assert property ((!busy && !en) [*3] |-> rts_b_o)
    else $error("ready to receive while disabled");
  cts_gate_a: assert property ((en && c3[9] && cts_b_i && hi > 8'hc8) [*6]
    |=> tx_o) else $error("frame started while held");
  cts_irq_a: assert property (!busy && en && c3[9] && c3[10] && $changed(cts_b_i)
    |-> ##[1:4] irq_o) else $error("no interrupt on flow input change");
  dma_rx_a: assert property (!busy && !c3[6] |-> !dma_rx_req_o)
    else $error("receive request while off");
  dma_tx_a: assert property (!busy && !c3[7] |-> !dma_tx_req_o)
    else $error("transmit request while off");
  oe_full_a: assert property (!busy && !c3[3] |-> tx_oe_o)
    else $error("driver off in full duplex");
  cover property ($fell(rts_b_o));
  cover property ($rose(irq_o));
  cover property (en && c3[9] && $fell(tx_o));
endmodule
bind serial_ctrl3_top serial_ctrl3_checker u_chk (.core_clk_i, .rst_b_i, .awaddr_i, .awvalid_i,
  .awready_o, .wdata_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .tx_o, .tx_oe_o,
  .cts_b_i, .rts_b_o, .ir_low_power_o, .dma_rx_req_o, .dma_tx_req_o, .irq_o);

// [sim/remote_serial_model.sv]
// Remote transceiver: sends frames to the device, decodes frames from it
// Assumes the reset baud divider, one bit lasting 17 clocks
`timescale 1ns/10ps
module remote_serial_model (
  // Clock and lines
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic hold_i,
  output logic       line_o,
  output logic       cts_b_o,
  // Last decoded character
  output logic [7:0] got_o,
  output int         cnt_o
);
  localparam int BIT_CYC = 17;
  initial line_o = 1'b1;
  initial got_o = 8'h00;
  initial cnt_o = 0;
  // Low lets the device send; the bench holds it high to stall
  assign cts_b_o = hold_i;
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  always begin
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      got_o[i] = line_i;
    end
    repeat (2 * BIT_CYC) @(posedge clk_i);
    cnt_o++;
  end
endmodule

// [sim/tb.sv]
// Bench for the serial control top: registers, mode bits, flow control
// Assumes the remote model on the line and the bound checker
`timescale 1ns/10ps
`include "serial_ctrl3_consts.svh"
module tb;
  import serial_ctrl3_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic [7:0]  awaddr_i   = 8'h00;
  logic [7:0]  araddr_i   = 8'h00;
  logic [31:0] wdata_i    = 32'h0;
  logic        awvalid_i  = 1'b0;
  logic        wvalid_i   = 1'b0;
  logic        arvalid_i  = 1'b0;
  logic        hold       = 1'b1;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, rx_i, tx_o, tx_oe_o;
  logic        cts_b_i, rts_b_o, ir_low_power_o, dma_rx_req_o, dma_tx_req_o, irq_o;
  logic [1:0]  bresp_o, rresp_o, rsp;
  logic [31:0] rdata_o;
  logic [7:0]  got;
  int          cnt;
  int          error_cnt   = 0;
  int          comparisons = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  serial_ctrl3_top dut (.core_clk_i, .rst_b_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
    .wstrb_i(4'hf), .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i(1'b1), .araddr_i,
    .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i(1'b1), .rx_i, .tx_o,
    .tx_oe_o, .cts_b_i, .rts_b_o, .ir_low_power_o, .dma_rx_req_o, .dma_tx_req_o, .irq_o);
  remote_serial_model partner (.clk_i(core_clk_i), .line_i(tx_o), .hold_i(hold),
    .line_o(rx_i), .cts_b_o(cts_b_i), .got_o(got), .cnt_o(cnt));
  // ****************
  // Tasks
  // ****************
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("BAD at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic fc(input logic g, input logic e);
    ck({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) break;
    end
    if (n == 50) tmo();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    int n;
    @(posedge core_clk_i);
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_i);
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) break;
    end
    if (n == 50) tmo();
    rsp = rresp_o;
    ck(rdata_o, e);
  endtask
  task automatic wait_got(input int c);
    int n;
    for (n = 0; n < 1000 && cnt < c; n++) @(posedge core_clk_i);
    if (n == 1000) tmo();
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rc(`OFS_CONTROL_THREE, {20'h0, `CTRL3_RESET});
    rc(`OFS_BAUD, {16'h0, `BAUD_RESET});
    rc(`OFS_STATUS, {27'h0, `STATUS_RESET});
    rc(8'h04, 32'h0);
    ck({30'h0, rsp}, 32'h2);
    $display("Register reset test done");
    wr(`OFS_CONTROL_THREE, 32'hffc);
    fc(ir_low_power_o, 1'b0);
    wr(`OFS_CONTROL_ONE, 32'h1);
    fc(ir_low_power_o, 1'b1);
    fc(tx_oe_o, 1'b0);
    wr(`OFS_CONTROL_THREE, 32'h0);
    rc(`OFS_CONTROL_THREE, {20'h0, `CTRL3_LOCKED_MASK});
    wr(`OFS_CONTROL_THREE, 32'hc0);
    fc(dma_tx_req_o, 1'b1);
    fc(dma_rx_req_o, 1'b0);
    wr(`OFS_CONTROL_ONE, 32'h0);
    fc(ir_low_power_o, 1'b0);
    $display("Mode bit test done");
    wr(`OFS_CONTROL_THREE, 32'h700);
    wr(`OFS_CONTROL_ONE, 32'h1);
    wr(`OFS_TX_DATA, 32'ha5);
    fc(rts_b_o, 1'b0);
    repeat (300) @(posedge core_clk_i);
    ck(cnt, 0);
    hold <= 1'b0;
    wait_got(1);
    ck({24'h0, got}, 32'ha5);
    fc(irq_o, 1'b1);
    wr(`OFS_STATUS, 32'h1);
    fc(irq_o, 1'b0);
    wr(`OFS_TX_DATA, 32'h5a);
    repeat (4) @(posedge core_clk_i);
    wr(`OFS_TX_DATA, 32'h81);
    hold <= 1'b1;
    wait_got(2);
    repeat (300) @(posedge core_clk_i);
    ck({24'h0, got}, 32'h5a);
    ck(cnt, 2);
    hold <= 1'b0;
    wait_got(3);
    ck({24'h0, got}, 32'h81);
    partner.send(8'h3c);
    repeat (2) @(posedge core_clk_i);
    fc(rts_b_o, 1'b1);
    fc(dma_rx_req_o, 1'b0);
    rc(`OFS_RX_DATA, 32'h3c);
    repeat (2) @(posedge core_clk_i);
    fc(rts_b_o, 1'b0);
    $display("Flow control test done");
    wrap_up();
  end
endmodule
